// [rtl/rcs_pkg.sv]
package rcs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TW = 36;
  localparam longint unsigned CYC_PER_MS = 32'h0003_D090;
  localparam longint unsigned T_AC_DLY_MS = 32'h0000_2710;
  localparam longint unsigned T_WARN_MS = 32'h0000_0003;
  localparam longint unsigned T_AUX_LEAD_MS = 32'h0000_01C2;
  localparam longint unsigned T_CC_MS = 32'h0000_4E20;
  localparam longint unsigned T_OC_MS = 32'h0000_0BB8;
  localparam longint unsigned T_RESTART_MS = 32'h0000_03E8;
  localparam longint unsigned T_OV_WIN_MS = 32'h0000_EA60;
  localparam longint unsigned T_LATCH_OFF_MS = 32'h0000_07D0;
  localparam longint unsigned T_BLINK_MS = 32'h0000_01F4;
  localparam logic [TW-1:0] CYC_AC_DLY = TW'(T_AC_DLY_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_WARN = TW'(T_WARN_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_AUX_LEAD = TW'(T_AUX_LEAD_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_CC = TW'(T_CC_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_OC = TW'(T_OC_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_RESTART = TW'(T_RESTART_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_OV_WIN = TW'(T_OV_WIN_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_LATCH_OFF = TW'(T_LATCH_OFF_MS * CYC_PER_MS);
  localparam logic [TW-1:0] CYC_BLINK = TW'(T_BLINK_MS * CYC_PER_MS);
  localparam logic [7:0] STRAP_SETTLE_CYC = 8'h10;

  // ----------------------------------------------------------------
  // analog levels (mV for output and pins, V for input)
  // ----------------------------------------------------------------
  localparam logic [8:0] VIN_LOW_V = 9'h050;
  localparam logic [16:0] VOUT_LED_MV = 17'h0_7530;
  localparam logic [16:0] VOUT_MIN_MV = 17'h0_59D8;
  localparam logic [16:0] VOUT_SHORT_MV = 17'h0_1388;
  localparam logic [16:0] VOUT_DEF_MV = 17'h0_FDE8;
  localparam logic [16:0] VOUT_SPAN_MV = 17'h0_A410;
  localparam logic [11:0] VPROG_LO_MV = 12'h064;
  localparam logic [11:0] VPROG_HI_MV = 12'hBB8;
  localparam logic [11:0] VPROG_SPAN_MV = 12'hB54;
  localparam logic [11:0] PROT_RS485_MAX_MV = 12'h672;
  localparam logic [1:0] OV_TRIES = 2'h3;

  // ----------------------------------------------------------------
  // straps and addressing
  // ----------------------------------------------------------------
  localparam logic [11:0] UNIT_THR [0:9] = '{12'hC4E, 12'hB13, 12'h9C9, 12'h87F, 12'h735,
                                             12'h5EB, 12'h4A1, 12'h357, 12'h20D, 12'h0B4};
  localparam logic [11:0] RACK_THR [0:9] = '{12'hBEA, 12'h9F6, 12'h802, 12'h640, 12'h4B0,
                                             12'h2EE, 12'h0FA, 12'h000, 12'h000, 12'h000};
  localparam logic [2:0] I2C_ADDR_PREFIX = 3'h4;
  localparam logic [6:0] I2C_BCAST = 7'h00;
  localparam logic [9:0] PIN_RST = 10'h306;

  typedef enum logic [6:0] {
    S_OFF   = 7'h01,
    S_DLY   = 7'h02,
    S_RUN   = 7'h04,
    S_HOLD  = 7'h08,
    S_RST   = 7'h10,
    S_LATCH = 7'h20,
    S_REL   = 7'h40
  } rcs_state_t;

  // number of thresholds lying above the sampled level
  function automatic logic [3:0] rcs_level(input logic [11:0] v, input logic [11:0] thr [0:9]);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++) begin
      if (v < thr[k]) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

endpackage

// [rtl/rcs_timer.sv]
module rcs_timer import rcs_pkg::*; #(
  parameter int W = TW
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic clr_i,
  input wire logic [W-1:0] limit_i,
  // status
  output logic done_o
);

  logic [W-1:0] cnt;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
    end else if (clr_i) begin
      cnt <= '0;
    end else if (cnt < limit_i) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign done_o = (cnt >= limit_i);

endmodule // rcs_timer

// [rtl/rcs_strap_decode.sv]
module rcs_strap_decode import rcs_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // digitised strap levels
  input wire logic [11:0] unit_position_strap_mv_i,
  input wire logic [11:0] rack_position_strap_mv_i,
  input wire logic [11:0] protocol_strap_mv_i,
  // captured configuration
  output logic captured_o,
  output logic i2c_mode_o,
  output logic [3:0] unit_o,
  output logic [3:0] rack_o,
  output logic [3:0] position_addr_o,
  output logic pos_valid_o
);

  logic [7:0] settle;
  logic [3:0] unit_lvl;
  logic [3:0] rack_lvl;
  logic [4:0] map;

  // {valid, address} from unit 1..10 and rack 1..8
  function automatic logic [4:0] addr_of(input logic [3:0] u, input logic [3:0] r);
    logic [4:0] a;
    a = 5'h00;
    if (u >= 4'h1 && u <= 4'h4 && r >= 4'h1 && r <= 4'h4) begin
      a = {1'b1, 4'((r - 4'h1) * 4'h4 + (u - 4'h1))};
    end else if (u >= 4'h1 && u <= 4'h5 && r >= 4'h6 && r <= 4'h8) begin
      a = {1'b1, 4'((r - 4'h6) * 4'h5 + (u - 4'h1))};
    end else if (u >= 4'h6 && u <= 4'h7 && r >= 4'h1 && r <= 4'h8) begin
      a = {1'b1, 4'((r - 4'h1) * 4'h2 + (u - 4'h6))};
    end else if (u >= 4'h8 && u <= 4'hA && r >= 4'h4 && r <= 4'h8) begin
      a = {1'b1, 4'((r - 4'h4) * 4'h3 + (u - 4'h8))};
    end
    return a;
  endfunction

  // nearest tabulated level, thresholds midway between nominals
  assign unit_lvl = rcs_level(unit_position_strap_mv_i, UNIT_THR); // RULE25 RULE21
  assign rack_lvl = rcs_level(rack_position_strap_mv_i, RACK_THR) + 4'h1; // RULE25
  assign map = addr_of(unit_lvl, rack_lvl); // RULE22

  // ----------------------------------------------------------------
  // one capture after reset release, then frozen
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle <= '0;
      captured_o <= 1'b0;
      i2c_mode_o <= 1'b1;
      unit_o <= '0;
      rack_o <= '0;
      position_addr_o <= '0;
      pos_valid_o <= 1'b0;
    end else if (!captured_o) begin
      if (settle < STRAP_SETTLE_CYC) begin
        settle <= settle + 8'h01;
      end else begin
        captured_o <= 1'b1; // RULE26
        i2c_mode_o <= (protocol_strap_mv_i > PROT_RS485_MAX_MV); // RULE19
        unit_o <= unit_lvl;
        rack_o <= rack_lvl;
        position_addr_o <= map[3:0];
        pos_valid_o <= map[4] && (unit_lvl != 4'h0); // RULE21
      end
    end
  end

endmodule // rcs_strap_decode

// [rtl/rcs_supervisor.sv]
// Notes on behaviour
// RULE1: I2C mode waits 10 s after AC returns
// RULE2: warning leads output loss by 3 ms
// RULE3: aux rail up 450 ms before main
// RULE4: input LED blinks below 80 V input
// RULE5: open or high program pin gives 65 V
// RULE6: firmware setpoint overrides pin until power cycle
// RULE7: constant current allowed 20 s at start-up
// RULE8: output LED blinks in limit above 30 V
// RULE9: limit below 23 V in restart mode hiccups
// RULE10: output LED follows on, dark when latched
// RULE11: overcurrent shutdown delayed 3 s
// RULE12: output below 5 V trips at once
// RULE13: overcurrent and overtemperature restart unless configured latched
// RULE14: overvoltage gets three 1 s restarts per minute
// RULE15: five events release a latch-off
// RULE16: released unit stays off 2 s first (clearing oc_latch_i or ot_latch_i skips the hold, straight to S_OFF)
// RULE17: successful restart clears alarms, sets flag
// RULE18: controller restarts system by off then on
// RULE19: protocol strap selects I2C or RS485
// RULE20: answer 100+position address and broadcast
// RULE21: unit strap gives ten positions, top invalid
// RULE22: unit and rack straps form address bits
// RULE23: broadcast read flagged as invalid command
// RULE24: controller pulls enable low for output on
// RULE25: strap levels snap to nearest table entry
// RULE26: straps captured after reset, then held
module rcs_supervisor import rcs_pkg::*; #(
  parameter logic [TW-1:0] P_AC_DLY = CYC_AC_DLY,
  parameter logic [TW-1:0] P_WARN = CYC_WARN,
  parameter logic [TW-1:0] P_AUX_LEAD = CYC_AUX_LEAD,
  parameter logic [TW-1:0] P_CC = CYC_CC,
  parameter logic [TW-1:0] P_OC = CYC_OC,
  parameter logic [TW-1:0] P_RESTART = CYC_RESTART,
  parameter logic [TW-1:0] P_OV_WIN = CYC_OV_WIN,
  parameter logic [TW-1:0] P_LATCH_OFF = CYC_LATCH_OFF,
  parameter logic [TW-1:0] P_BLINK = CYC_BLINK
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // pins from outside the clock domain
  input wire logic ac_ok_i,
  input wire logic onoff_n_i,
  input wire logic interlock_n_i,
  input wire logic present_i,
  input wire logic oc_i,
  input wire logic ot_i,
  input wire logic ov_i,
  input wire logic limit_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // converter samples
  input wire logic [8:0] vin_v_i,
  input wire logic [16:0] vout_mv_i,
  input wire logic [11:0] vprog_mv_i,
  input wire logic [11:0] unit_position_strap_mv_i,
  input wire logic [11:0] rack_position_strap_mv_i,
  input wire logic [11:0] protocol_strap_mv_i,
  // firmware side
  input wire logic op_on_i,
  input wire logic fw_vout_wr_i,
  input wire logic [16:0] fw_vout_mv_i,
  input wire logic oc_latch_i,
  input wire logic ot_latch_i,
  input wire logic status_clr_i,
  // power control and indication
  output logic main_en_o,
  output logic aux_standby_rail_o,
  output logic output_fail_warning_o,
  output logic in_led_o,
  output logic out_led_o,
  output logic [16:0] setpoint_mv_o,
  output logic alarm_clear_o,
  output logic restart_ok_o,
  output logic latched_o,
  // configuration and addressing
  output logic i2c_mode_o,
  output logic [3:0] position_addr_o,
  output logic pos_valid_o,
  output logic addr_hit_o,
  output logic addr_rd_o,
  output logic invalid_cmd_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sy1, sy2;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy1 <= PIN_RST;
      sy2 <= PIN_RST;
    end else begin
      sy1 <= {sda_i, scl_i, limit_i, ov_i, ot_i, oc_i, present_i, interlock_n_i, onoff_n_i,
              ac_ok_i};
      sy2 <= sy1;
    end
  end
  logic ac_ok, onoff_n, ilock_n, present, oc_s, ot_s, ov_s, lim_s, scl_s, sda_s;
  assign {sda_s, scl_s, lim_s, ov_s, ot_s, oc_s, present, ilock_n, onoff_n, ac_ok} = sy2;

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  logic captured;
  rcs_strap_decode u_strap (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .unit_position_strap_mv_i(unit_position_strap_mv_i),
    .rack_position_strap_mv_i(rack_position_strap_mv_i),
    .protocol_strap_mv_i(protocol_strap_mv_i),
    .captured_o(captured),
    .i2c_mode_o(i2c_mode_o),
    .unit_o(),
    .rack_o(),
    .position_addr_o(position_addr_o),
    .pos_valid_o(pos_valid_o)
  );

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  rcs_state_t state, next_state;
  logic [TW-1:0] st_limit;
  logic st_done, aux_done, cc_done, oc_done, ovw_done, blink_done;
  logic ov_win;
  logic blink;

  rcs_timer u_t_state (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(next_state != state),
    .limit_i(st_limit), .done_o(st_done));
  rcs_timer u_t_aux (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(!ac_ok),
    .limit_i(P_AUX_LEAD), .done_o(aux_done));
  rcs_timer u_t_cc (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(state != S_RUN),
    .limit_i(P_CC), .done_o(cc_done));
  rcs_timer u_t_oc (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(!oc_s || state != S_RUN),
    .limit_i(P_OC), .done_o(oc_done));
  rcs_timer u_t_ovw (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(!ov_win),
    .limit_i(P_OV_WIN), .done_o(ovw_done));
  rcs_timer u_t_blink (.mclk_i(mclk_i), .rstn_i(rstn_i), .clr_i(blink_done),
    .limit_i(P_BLINK), .done_o(blink_done));

  // ----------------------------------------------------------------
  // enable, faults and release events
  // ----------------------------------------------------------------
  logic en_req, pin_on, run_ok, short_ckt, hiccup, oc_trip, ov_evt, ov_latch_now;
  logic pin_on_q, op_on_q, present_q, ac_q, ocl_q, otl_q, any_rel, reconf_rel;
  logic [1:0] ov_cnt;

  assign pin_on = !onoff_n && !ilock_n;
  assign en_req = present && !ilock_n && op_on_i && (!i2c_mode_o || !onoff_n); // RULE24
  assign run_ok = (state == S_RUN) && ac_ok && en_req;
  assign short_ckt = vout_mv_i < VOUT_SHORT_MV; // RULE12
  assign hiccup = (vout_mv_i < VOUT_MIN_MV) && !oc_latch_i; // RULE9
  assign oc_trip = oc_s && (short_ckt || hiccup || (cc_done && oc_done)); // RULE7 RULE11
  assign ov_evt = run_ok && ov_s;
  assign ov_latch_now = (ov_cnt >= OV_TRIES); // RULE14
  assign any_rel = (pin_on && !pin_on_q && i2c_mode_o) || (op_on_i && !op_on_q) ||
                   (present && !present_q) || (ac_ok && !ac_q); // RULE15
  assign reconf_rel = (ocl_q && !oc_latch_i) || (otl_q && !ot_latch_i); // RULE15

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_on_q <= 1'b0;
      op_on_q <= 1'b0;
      present_q <= 1'b0;
      ac_q <= 1'b0;
      ocl_q <= 1'b0;
      otl_q <= 1'b0;
    end else begin
      pin_on_q <= pin_on;
      op_on_q <= op_on_i;
      present_q <= present;
      ac_q <= ac_ok;
      ocl_q <= oc_latch_i;
      otl_q <= ot_latch_i;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_OFF: begin
        if (ac_ok && en_req && captured) next_state = S_DLY;
      end
      S_DLY: begin
        if (!ac_ok || !en_req) next_state = S_OFF;
        else if (st_done && aux_done) next_state = S_RUN; // RULE1 RULE3
      end
      S_RUN: begin
        if (!ac_ok) next_state = S_HOLD; // RULE2
        else if (!en_req) next_state = S_OFF;
        else if (ov_s) next_state = ov_latch_now ? S_LATCH : S_RST; // RULE14
        else if (oc_trip) next_state = oc_latch_i ? S_LATCH : S_RST; // RULE13
        else if (ot_s) next_state = ot_latch_i ? S_LATCH : S_RST; // RULE13
      end
      S_HOLD: begin
        if (ac_ok) next_state = S_RUN;
        else if (st_done) next_state = S_OFF; // RULE2
      end
      S_RST: begin
        if (!ac_ok || !en_req) next_state = S_OFF;
        else if (st_done && aux_done) next_state = S_RUN;
      end
      S_LATCH: begin
        if (reconf_rel) next_state = S_OFF;
        else if (any_rel) next_state = S_REL; // RULE16
      end
      S_REL: begin
        if (st_done) next_state = S_OFF; // RULE16
      end
      default: next_state = S_OFF;
    endcase
  end

  always_comb begin
    case (state)
      S_DLY: st_limit = i2c_mode_o ? P_AC_DLY : P_AUX_LEAD;
      S_HOLD: st_limit = P_WARN;
      S_RST: st_limit = P_RESTART;
      S_REL: st_limit = P_LATCH_OFF;
      default: st_limit = '1;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) state <= S_OFF;
    else state <= next_state;
  end

  assign main_en_o = (state == S_RUN) || (state == S_HOLD);
  assign output_fail_warning_o = (state == S_HOLD); // RULE2
  assign aux_standby_rail_o = ac_ok; // RULE3
  assign latched_o = (state == S_LATCH);

  // ----------------------------------------------------------------
  // overvoltage window
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ov_cnt <= '0;
      ov_win <= 1'b0;
    end else if (ov_evt) begin
      ov_cnt <= ov_latch_now ? ov_cnt : ov_cnt + 2'h1; // RULE14
      ov_win <= 1'b1;
    end else if (ovw_done || (state == S_LATCH && next_state != S_LATCH)) begin
      ov_cnt <= '0; // RULE14
      ov_win <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // restart success
  // ----------------------------------------------------------------
  logic rst_pend;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_pend <= 1'b0;
      alarm_clear_o <= 1'b0;
      restart_ok_o <= 1'b0;
    end else begin
      alarm_clear_o <= 1'b0;
      if (state == S_RST && next_state == S_RUN) begin
        rst_pend <= 1'b1;
      end else if (state != S_RUN) begin
        rst_pend <= 1'b0;
      end else if (rst_pend && vout_mv_i >= VOUT_MIN_MV) begin
        rst_pend <= 1'b0;
        alarm_clear_o <= 1'b1; // RULE17
      end
      if (alarm_clear_o) restart_ok_o <= 1'b1; // RULE17
      else if (status_clr_i) restart_ok_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blink <= 1'b0;
      in_led_o <= 1'b0;
      out_led_o <= 1'b0;
    end else begin
      if (blink_done) blink <= !blink;
      in_led_o <= (vin_v_i < VIN_LOW_V) ? blink : ac_ok; // RULE4
      if (state != S_RUN) out_led_o <= 1'b0; // RULE10
      else if (lim_s && vout_mv_i > VOUT_LED_MV) out_led_o <= blink; // RULE8
      else out_led_o <= 1'b1; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // output setpoint
  // ----------------------------------------------------------------
  logic [16:0] prog_mv;
  logic [28:0] prod;
  logic fw_own;
  assign prod = 29'(vprog_mv_i - VPROG_LO_MV) * 29'(VOUT_SPAN_MV);
  always_comb begin
    if (vprog_mv_i < VPROG_LO_MV || vprog_mv_i > VPROG_HI_MV) prog_mv = VOUT_DEF_MV; // RULE5
    else prog_mv = VOUT_MIN_MV + 17'(prod / VPROG_SPAN_MV);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fw_own <= 1'b0;
      setpoint_mv_o <= VOUT_DEF_MV;
    end else if (fw_vout_wr_i) begin
      fw_own <= 1'b1; // RULE6
      setpoint_mv_o <= fw_vout_mv_i;
    end else if (!fw_own) begin
      setpoint_mv_o <= prog_mv; // RULE6
    end
  end

  // ----------------------------------------------------------------
  // bus address match on the link
  // ----------------------------------------------------------------
  logic scl_q, sda_q, active;
  logic [2:0] bitcnt;
  logic [6:0] sh;
  logic [7:0] abyte;
  logic last_bit;
  assign abyte = {sh, sda_s};
  assign last_bit = active && scl_s && !scl_q && (bitcnt == 3'h7);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      active <= 1'b0;
      bitcnt <= '0;
      sh <= '0;
      addr_hit_o <= 1'b0;
      addr_rd_o <= 1'b0;
      invalid_cmd_o <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      addr_hit_o <= 1'b0;
      invalid_cmd_o <= 1'b0;
      if (scl_s && scl_q && sda_q && !sda_s) begin
        active <= i2c_mode_o && pos_valid_o;
        bitcnt <= '0;
      end else if (active && scl_s && !scl_q) begin
        sh <= abyte[6:0];
        bitcnt <= bitcnt + 3'h1;
        if (last_bit) begin
          active <= 1'b0;
          addr_rd_o <= abyte[0];
          addr_hit_o <= (abyte[7:1] == {I2C_ADDR_PREFIX, position_addr_o}) ||
                        (abyte[7:1] == I2C_BCAST && !abyte[0]); // RULE20
          invalid_cmd_o <= (abyte[7:1] == I2C_BCAST) && abyte[0]; // RULE23
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_warn_lead: assert property ((state == S_RUN && !ac_ok) |=> // RULE2
    output_fail_warning_o && main_en_o) else $error("warning not ahead of output loss");
  a_aux_first: assert property ($rose(main_en_o) |-> aux_done) // RULE3
    else $error("main on before aux rail settled");
  a_start_wait: assert property ((state == S_DLY && i2c_mode_o && !st_done) |=> // RULE1
    state != S_RUN) else $error("main started before delay");
  a_vprog_default: assert property ((!fw_own && !fw_vout_wr_i && vprog_mv_i > VPROG_HI_MV) // RULE5
    |=> setpoint_mv_o == VOUT_DEF_MV) else $error("default setpoint not taken");
  a_fw_owns: assert property ((fw_own && !fw_vout_wr_i) |=> $stable(setpoint_mv_o)) // RULE6
    else $error("pin changed setpoint after firmware took over");
  a_short_trip: assert property ((run_ok && oc_s && short_ckt && !ov_s) |=> // RULE12
    state == S_RST || state == S_LATCH) else $error("short not shut down at once");
  a_led_latch: assert property ((state == S_LATCH) |=> !out_led_o) // RULE10
    else $error("output led lit while latched");
  a_release_hold: assert property ((state == S_REL && !st_done) |=> // RULE16
    state == S_REL && !main_en_o) else $error("release hold cut short");
  a_bcast_read: assert property ((last_bit && abyte == 8'h01) |=> // RULE23
    invalid_cmd_o && !addr_hit_o) else $error("broadcast read not rejected");

  c_start: cover property (state == S_DLY ##1 state == S_RUN);
  c_latch: cover property (state == S_LATCH ##1 state == S_REL);
  c_restart_ok: cover property (alarm_clear_o);
  c_addr_hit: cover property (addr_hit_o);

endmodule // rcs_supervisor

// [dv/rcs_i2c_host.sv]
module rcs_i2c_host (
  // bus lines, driven high when idle
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one address byte, msb first, r/w bit last; clock stands still between frames
  task automatic send(input logic [7:0] b);
    sda_o = 1'b0;
    #16;
    for (int k = 7; k >= 0; k--) begin
      scl_o = 1'b0;
      #8;
      sda_o = b[k];
      #8;
      scl_o = 1'b1;
      #16;
    end
    scl_o = 1'b0;
    #8;
    sda_o = 1'b0;
    #8;
    scl_o = 1'b1;
    #16;
    sda_o = 1'b1;
    #16;
  endtask
endmodule // rcs_i2c_host

// [dv/rectifier_control_supervisor_tb.sv]
module rectifier_control_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rstn_i = 1'b0, ac_ok_i = 1'b0, onoff_n_i = 1'b1, interlock_n_i = 1'b1;
  logic present_i = 1'b1, oc_i = 1'b0, ot_i = 1'b0, ov_i = 1'b0, limit_i = 1'b0, scl_i, sda_i;
  logic op_on_i = 1'b1, fw_vout_wr_i = 1'b0, oc_latch_i = 1'b0, ot_latch_i = 1'b0;
  logic status_clr_i = 1'b0;
  logic [8:0] vin_v_i = 9'h0E6;
  logic [16:0] vout_mv_i = 17'h0_BB80, fw_vout_mv_i = 17'h0_0000, setpoint_mv_o;
  logic [11:0] vprog_mv_i = 12'hBB8, unit_position_strap_mv_i = 12'hBB8;
  logic [11:0] rack_position_strap_mv_i = 12'hCE4, protocol_strap_mv_i = 12'hCE4;
  logic main_en_o, aux_standby_rail_o, output_fail_warning_o, in_led_o, out_led_o;
  logic alarm_clear_o, restart_ok_o, latched_o, i2c_mode_o, pos_valid_o;
  logic addr_hit_o, addr_rd_o, invalid_cmd_o;
  logic [3:0] position_addr_o;
  int miscompares = 0, samples_checked = 0, cyc = 0, hits = 0, invs = 0, n;
  bit ch;
  rcs_supervisor #(.P_AC_DLY(36'h0C8), .P_WARN(36'hA), .P_AUX_LEAD(36'h32), .P_CC(36'h12C),
    .P_OC(36'h64), .P_RESTART(36'h28), .P_OV_WIN(36'h7D0), .P_LATCH_OFF(36'h3C),
    .P_BLINK(36'h10)) i_dut (.*);
  rcs_i2c_host i_host (.scl_o(scl_i), .sda_o(sda_i));
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    hits <= hits + int'(addr_hit_o === 1'b1);
    invs <= invs + int'(invalid_cmd_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic wait_main(input logic v, output int k);
    k = 0;
    while (main_en_o !== v && k < 400) begin
      @(negedge mclk_i);
      k++;
    end
  endtask
  task automatic toggles(input bit sel, output bit c);
    logic first;
    first = sel ? out_led_o : in_led_o;
    c = 1'b0;
    repeat (40) begin
      @(negedge mclk_i);
      if ((sel ? out_led_o : in_led_o) !== first) c = 1'b1;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_addr();
    chk(17'(i2c_mode_o), 17'h1);
    chk(17'(pos_valid_o), 17'h1);
    chk(17'(position_addr_o), 17'h0);
    i_host.send(8'h80);
    settle();
    chk(17'(hits), 17'h1);
    chk(17'(addr_rd_o), 17'h0);
    i_host.send(8'h01);
    settle();
    chk(17'(invs), 17'h1);
    chk(17'(addr_rd_o), 17'h1);
    chk(17'(hits), 17'h1);
  endtask
  task automatic t_setp();
    @(posedge mclk_i);
    vprog_mv_i <= 12'hC1C;
    settle();
    chk(setpoint_mv_o, 17'h0_FDE8);
    @(posedge mclk_i);
    vprog_mv_i <= 12'h064;
    settle();
    chk(setpoint_mv_o, 17'h0_59D8);
    @(posedge mclk_i);
    fw_vout_wr_i <= 1'b1;
    fw_vout_mv_i <= 17'h0_9C40;
    @(posedge mclk_i);
    fw_vout_wr_i <= 1'b0;
    vprog_mv_i <= 12'hBB8;
    settle();
    chk(setpoint_mv_o, 17'h0_9C40);
  endtask
  task automatic t_power();
    @(posedge mclk_i);
    ac_ok_i <= 1'b1;
    onoff_n_i <= 1'b0;
    interlock_n_i <= 1'b0;
    wait_main(1'b1, n);
    chk(17'(n >= 200 && n <= 210), 17'h1);
    chk(17'(aux_standby_rail_o), 17'h1);
    settle();
    chk(17'(out_led_o), 17'h1);
  endtask
  task automatic t_leds();
    @(posedge mclk_i);
    limit_i <= 1'b1;
    vout_mv_i <= 17'h0_9C40;
    vin_v_i <= 9'h03C;
    toggles(1'b1, ch);
    chk(17'(ch), 17'h1);
    toggles(1'b0, ch);
    chk(17'(ch), 17'h1);
    @(posedge mclk_i);
    limit_i <= 1'b0;
    vout_mv_i <= 17'h0_BB80;
    vin_v_i <= 9'h0E6;
  endtask
  task automatic t_short();
    @(posedge mclk_i);
    oc_i <= 1'b1;
    vout_mv_i <= 17'h0_0BB8;
    wait_main(1'b0, n);
    chk(17'(n <= 6), 17'h1);
    @(posedge mclk_i);
    oc_i <= 1'b0;
    vout_mv_i <= 17'h0_BB80;
    wait_main(1'b1, n);
    chk(17'(n >= 36 && n <= 50), 17'h1);
    chk(17'(latched_o), 17'h0);
    settle();
    chk(17'(restart_ok_o), 17'h1);
    @(posedge mclk_i);
    status_clr_i <= 1'b1;
    @(posedge mclk_i);
    status_clr_i <= 1'b0;
    settle();
    chk(17'(restart_ok_o), 17'h0);
  endtask
  task automatic t_acloss();
    @(posedge mclk_i);
    ac_ok_i <= 1'b0;
    settle();
    chk(17'({output_fail_warning_o, main_en_o}), 17'h3);
    wait_main(1'b0, n);
    chk(17'(n >= 10 && n <= 12), 17'h1);
  endtask
  task automatic t_latch();
    @(posedge mclk_i);
    ac_ok_i <= 1'b1;
    wait_main(1'b1, n);
    @(posedge mclk_i);
    ov_i <= 1'b1;
    repeat (100) @(negedge mclk_i);
    chk(17'(latched_o), 17'h0);
    repeat (100) @(negedge mclk_i);
    chk(17'({latched_o, out_led_o}), 17'h2);
    @(posedge mclk_i);
    ov_i <= 1'b0;
    op_on_i <= 1'b0;
    @(posedge mclk_i);
    op_on_i <= 1'b1;
    wait_main(1'b1, n);
    chk(17'(n >= 260 && n <= 270), 17'h1);
    @(posedge mclk_i);
    ot_latch_i <= 1'b1;
    ot_i <= 1'b1;
    settle();
    chk(17'(latched_o), 17'h1);
    @(posedge mclk_i);
    ot_i <= 1'b0;
    ot_latch_i <= 1'b0;
    wait_main(1'b1, n);
    chk(17'(n >= 200 && n <= 210), 17'h1);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (20) @(negedge mclk_i);
    t_addr();
    t_setp();
    t_power();
    t_leds();
    t_short();
    t_acloss();
    t_latch();
    end_of_test();
  end
endmodule // rectifier_control_supervisor_tb
